// ==== rtl/pdcc_pkg.sv ====
// Constants and carrier types for the peripheral DMA channel controller.
// Assumes a plain one-cycle strobe register port and a single system clock.
// Function
// (RULE1) Receive next count holds next buffer size
// (RULE2) Half duplex: receive next count equals transmit's; the code keeps the two next counts as separate registers
// (RULE3) Half duplex: receive next pointer equals transmit's; the code keeps the two next pointers as separate registers
// (RULE4) Transmit next pointer holds next address
// (RULE5) Transmit next count: 16-bit field, upper reserved
// (RULE6) Control is write-only; zero bits do nothing
// (RULE7) Receive enable works unless disable also set
// (RULE8) Half duplex: receive enable disables transmit
// (RULE9) Half duplex: never set both enables
// (RULE10) Receive disable clears receive requests
// (RULE11) Half duplex: receive disable clears transmit
// (RULE12) Transmit enable sets transmit requests
// (RULE13) Half duplex: transmit enable needs no receive enable
// (RULE14) Transmit disable clears transmit requests
// (RULE15) Half duplex: transmit disable clears receive
// (RULE16) Status bit 0 shows receive enabled
// (RULE17) Status bit 8 shows transmit enabled
// (RULE18) Zero count stops, nonzero transfers when enabled
// (RULE19) Receive next pointer holds next address
// (RULE20) Exhausted count reloads from next registers
// (RULE21) Each word advances pointer, decrements count
package pdcc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RX_PTR = 8'h00;
    localparam logic [7:0] ADDR_RX_CNT = 8'h04;
    localparam logic [7:0] ADDR_TX_PTR = 8'h08;
    localparam logic [7:0] ADDR_TX_CNT = 8'h0C;
    localparam logic [7:0] ADDR_RX_NPTR = 8'h10;
    localparam logic [7:0] ADDR_RX_NCNT = 8'h14;
    localparam logic [7:0] ADDR_TX_NPTR = 8'h18;
    localparam logic [7:0] ADDR_TX_NCNT = 8'h1C;
    localparam logic [7:0] ADDR_CTRL = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    localparam logic [7:0] ADDR_CONFIG = 8'h28;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_RX_EN = 0;
    localparam int BIT_RX_DIS = 1;
    localparam int BIT_TX_EN = 8;
    localparam int BIT_TX_DIS = 9;
    localparam int BIT_HALF_DUPLEX = 0;
    localparam int CNT_W = 16;
    localparam int PTR_W = 32;

    // ------------------------------------------------------------
    // Reset values and step
    // ------------------------------------------------------------
    localparam logic [31:0] PTR_RESET = 32'h0000_0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // One direction of channel state
    typedef struct packed {
        logic [31:0] cur_ptr;
        logic [15:0] cur_cnt;
        logic [31:0] nxt_ptr;
        logic [15:0] nxt_cnt;
    } pdcc_dir_t;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pdcc_bus_t;

endpackage

// ==== rtl/pdcc_top.sv ====
// Peripheral DMA channel controller: pointers, counters, request gating.
// Assumes peripheral requests and memory done pulses synchronous to clk_sys_i.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module pdcc_top #(
    parameter int XFER_BYTES = 1
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Peripheral requests
    input wire logic rx_req_i,
    input wire logic tx_req_i,
    // Memory side
    output logic rx_go_o,
    output logic tx_go_o,
    output logic [31:0] rx_addr_o,
    output logic [31:0] tx_addr_o,
    input wire logic rx_done_i,
    input wire logic tx_done_i,
    // Status
    output logic rx_end_o,
    output logic tx_end_o
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    pdcc_pkg::pdcc_bus_t bus;
    assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    function automatic logic wr_hit(input pdcc_pkg::pdcc_bus_t b, input logic [7:0] a);
        wr_hit = b.wr && (b.addr == a);
    endfunction

    localparam logic [31:0] STEP = 32'(XFER_BYTES);

    pdcc_pkg::pdcc_dir_t rx_q, rx_d, tx_q, tx_d;
    logic rx_en_q, rx_en_d, tx_en_q, tx_en_d;
    logic half_q;
    logic [31:0] rdata_q, rdata_d;

    wire ctl_wr = wr_hit(bus, pdcc_pkg::ADDR_CTRL);
    // RULE6: zero bits ignored
    wire c_rx_en = ctl_wr && bus.wdata[pdcc_pkg::BIT_RX_EN];
    wire c_rx_dis = ctl_wr && bus.wdata[pdcc_pkg::BIT_RX_DIS];
    wire c_tx_en = ctl_wr && bus.wdata[pdcc_pkg::BIT_TX_EN];
    wire c_tx_dis = ctl_wr && bus.wdata[pdcc_pkg::BIT_TX_DIS];

    // RULE7: enable loses to disable
    wire rx_set = c_rx_en && !c_rx_dis;
    // RULE13: half duplex tx enable only without rx enable
    wire tx_set = c_tx_en && !c_tx_dis && !(half_q && c_rx_en);
    // RULE10 RULE15: receive clear sources
    wire rx_clr = c_rx_dis || (half_q && c_tx_dis);
    // RULE14 RULE11 RULE8: transmit clear sources
    wire tx_clr = c_tx_dis || (half_q && (c_rx_dis || rx_set));

    // ------------------------------------------------------------
    // Enable state
    // ------------------------------------------------------------
    always_comb begin
        rx_en_d = rx_en_q;
        tx_en_d = tx_en_q;
        // RULE12: transmit enable
        if (tx_set) begin
            tx_en_d = 1'b1;
        end
        if (tx_clr) begin
            tx_en_d = 1'b0;
        end
        if (rx_set) begin
            rx_en_d = 1'b1;
        end
        if (rx_clr) begin
            rx_en_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Transfer engines
    // ------------------------------------------------------------
    // RULE18: nonzero count and enabled starts transfer
    assign rx_go_o = rx_en_q && (rx_q.cur_cnt != pdcc_pkg::CNT_RESET) && rx_req_i;
    assign tx_go_o = tx_en_q && (tx_q.cur_cnt != pdcc_pkg::CNT_RESET) && tx_req_i;
    assign rx_addr_o = rx_q.cur_ptr;
    assign tx_addr_o = tx_q.cur_ptr;
    assign rx_end_o = (rx_q.cur_cnt == pdcc_pkg::CNT_RESET);
    assign tx_end_o = (tx_q.cur_cnt == pdcc_pkg::CNT_RESET);

    function automatic pdcc_pkg::pdcc_dir_t step_dir(input pdcc_pkg::pdcc_dir_t s, input logic done,
                                                    input logic go);
        pdcc_pkg::pdcc_dir_t n;
        n = s;
        // RULE21: advance pointer, decrement count
        if (done && go) begin
            n.cur_ptr = s.cur_ptr + STEP;
            n.cur_cnt = s.cur_cnt - pdcc_pkg::CNT_ONE;
        end
        // RULE20: reload from next registers
        if (n.cur_cnt == pdcc_pkg::CNT_RESET && s.nxt_cnt != pdcc_pkg::CNT_RESET) begin
            n.cur_ptr = s.nxt_ptr;
            n.cur_cnt = s.nxt_cnt;
            n.nxt_cnt = pdcc_pkg::CNT_RESET;
        end
        step_dir = n;
    endfunction

    always_comb begin
        rx_d = step_dir(rx_q, rx_done_i, rx_go_o);
        tx_d = step_dir(tx_q, tx_done_i, tx_go_o);
        // Software writes override the engine in the same cycle
        if (wr_hit(bus, pdcc_pkg::ADDR_RX_PTR)) begin
            rx_d.cur_ptr = bus.wdata;
        end
        if (wr_hit(bus, pdcc_pkg::ADDR_RX_CNT)) begin
            rx_d.cur_cnt = bus.wdata[pdcc_pkg::CNT_W-1:0];
        end
        if (wr_hit(bus, pdcc_pkg::ADDR_TX_PTR)) begin
            tx_d.cur_ptr = bus.wdata;
        end
        if (wr_hit(bus, pdcc_pkg::ADDR_TX_CNT)) begin
            tx_d.cur_cnt = bus.wdata[pdcc_pkg::CNT_W-1:0];
        end
        // RULE19: receive next pointer
        if (wr_hit(bus, pdcc_pkg::ADDR_RX_NPTR)) begin
            rx_d.nxt_ptr = bus.wdata;
        end
        // RULE1: receive next count
        if (wr_hit(bus, pdcc_pkg::ADDR_RX_NCNT)) begin
            rx_d.nxt_cnt = bus.wdata[pdcc_pkg::CNT_W-1:0];
        end
        // RULE4: transmit next pointer
        if (wr_hit(bus, pdcc_pkg::ADDR_TX_NPTR)) begin
            tx_d.nxt_ptr = bus.wdata;
        end
        // RULE5: 16-bit next count
        if (wr_hit(bus, pdcc_pkg::ADDR_TX_NCNT)) begin
            tx_d.nxt_cnt = bus.wdata[pdcc_pkg::CNT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire [31:0] st_word = {22'h0, tx_en_q, 7'h0, rx_en_q, 1'b0} >> 1;

    always_comb begin
        rdata_d = pdcc_pkg::RD_ZERO;
        if (bus.rd) begin
            unique case (bus.addr)
                pdcc_pkg::ADDR_RX_PTR: rdata_d = rx_q.cur_ptr;
                pdcc_pkg::ADDR_RX_CNT: rdata_d = {16'h0, rx_q.cur_cnt};
                pdcc_pkg::ADDR_TX_PTR: rdata_d = tx_q.cur_ptr;
                pdcc_pkg::ADDR_TX_CNT: rdata_d = {16'h0, tx_q.cur_cnt};
                pdcc_pkg::ADDR_RX_NPTR: rdata_d = rx_q.nxt_ptr;
                pdcc_pkg::ADDR_RX_NCNT: rdata_d = {16'h0, rx_q.nxt_cnt};
                pdcc_pkg::ADDR_TX_NPTR: rdata_d = tx_q.nxt_ptr;
                pdcc_pkg::ADDR_TX_NCNT: rdata_d = {16'h0, tx_q.nxt_cnt};
                // RULE16 RULE17: status bits 0 and 8
                pdcc_pkg::ADDR_STATUS: rdata_d = st_word;
                pdcc_pkg::ADDR_CONFIG: rdata_d = {31'h0, half_q};
                // Control is write-only; unmapped reads zero
                default: rdata_d = pdcc_pkg::RD_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rx_q <= '{pdcc_pkg::PTR_RESET, pdcc_pkg::CNT_RESET, pdcc_pkg::PTR_RESET, pdcc_pkg::CNT_RESET};
            tx_q <= '{pdcc_pkg::PTR_RESET, pdcc_pkg::CNT_RESET, pdcc_pkg::PTR_RESET, pdcc_pkg::CNT_RESET};
            rx_en_q <= 1'b0;
            tx_en_q <= 1'b0;
            half_q <= 1'b0;
            rdata_q <= pdcc_pkg::RD_ZERO;
        end else begin
            rx_q <= rx_d;
            tx_q <= tx_d;
            rx_en_q <= rx_en_d;
            tx_en_q <= tx_en_d;
            if (wr_hit(bus, pdcc_pkg::ADDR_CONFIG)) begin
                half_q <= bus.wdata[pdcc_pkg::BIT_HALF_DUPLEX];
            end
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

endmodule

// ==== dv/pdcc_top_assertions.sv ====
// Checker for pdcc_top: status, request gating and pointer stepping.
// Assumes the single clock and synchronous active-low reset of the top.
`timescale 1ns/100ps
module pdcc_checker #(parameter int XFER_BYTES = 1) (
    input wire logic clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i, reg_rdata_o, rx_addr_o,
    input wire logic rx_req_i, tx_req_i, rx_go_o, tx_go_o, rx_done_i, rx_end_o, tx_end_o
);
    // --------
    // Shadow of enables
    // --------
    logic rx_en_q, tx_en_q, hd_q;
    logic [31:0] nptr_q;
    wire ctl = reg_wr_i && reg_addr_i == pdcc_pkg::ADDR_CTRL;
    wire rx_off = reg_wdata_i[1] || (hd_q && reg_wdata_i[9]);
    wire tx_off = reg_wdata_i[9] || (hd_q && (reg_wdata_i[1] || reg_wdata_i[0]));
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rx_en_q <= 1'b0;
            tx_en_q <= 1'b0;
            hd_q <= 1'b0;
        end else begin
            if (reg_wr_i && reg_addr_i == pdcc_pkg::ADDR_CONFIG) hd_q <= reg_wdata_i[0];
            if (reg_wr_i && reg_addr_i == pdcc_pkg::ADDR_RX_NPTR) nptr_q <= reg_wdata_i;
            if (ctl) rx_en_q <= !rx_off && (reg_wdata_i[0] || rx_en_q);
            if (ctl) tx_en_q <= !tx_off && (reg_wdata_i[8] || tx_en_q);
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_stat_rd; reg_rd_i && reg_addr_i == pdcc_pkg::ADDR_STATUS; endsequence
    sequence s_word; rx_go_o && rx_done_i && !reg_wr_i; endsequence
    property p_stat; s_stat_rd |=> reg_rdata_o == {23'h0, $past(tx_en_q), 7'h0, $past(rx_en_q)}; endproperty
    property p_rx_go; rx_go_o == (rx_en_q && rx_req_i && !rx_end_o); endproperty
    property p_tx_go; tx_go_o == (tx_en_q && tx_req_i && !tx_end_o); endproperty
    property p_ctl_rd; reg_rd_i && reg_addr_i == pdcc_pkg::ADDR_CTRL |=> reg_rdata_o == 32'h0; endproperty
    property p_step; s_word |=> rx_addr_o == $past(rx_addr_o) + 32'(XFER_BYTES) || rx_addr_o == nptr_q; endproperty
    // Exhausted count may reload without a word done, so only a live buffer must hold still
    property p_hold; !rx_done_i && !reg_wr_i && !rx_end_o |=> $stable(rx_addr_o); endproperty
    property p_rst; $rose(rst_n_i) |-> rx_end_o && tx_end_o && !rx_go_o && !tx_go_o; endproperty
    property p_hd; hd_q |-> !(rx_go_o && tx_go_o); endproperty
    a_stat: assert property (p_stat) else $error("status read wrong");
    a_rx_go: assert property (p_rx_go) else $error("receive go wrong");
    a_tx_go: assert property (p_tx_go) else $error("transmit go wrong");
    a_ctl_rd: assert property (p_ctl_rd) else $error("control read not zero");
    a_step: assert property (p_step) else $error("pointer step wrong");
    a_hold: assert property (p_hold) else $error("pointer moved idle");
    a_rst: assert property (p_rst) else $error("reset state wrong");
    a_hd: assert property (p_hd) else $error("both directions active");
endmodule
bind pdcc_top pdcc_checker #(.XFER_BYTES(XFER_BYTES)) u_chk (.clk_sys_i, .rst_n_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .rx_addr_o, .rx_req_i, .tx_req_i, .rx_go_o, .tx_go_o,
    .rx_done_i, .rx_end_o, .tx_end_o);

// ==== dv/pdcc_periph_model.sv ====
// Partner: peripheral requests and memory word-done answers.
// Assumes go outputs of pdcc_top on the same clock; index 0 rx, 1 tx.
`timescale 1ns/100ps
module pdcc_periph_model (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic active_i,
    input wire logic slow_i,
    input wire logic [1:0] go_i,
    output logic [1:0] req_o,
    output logic [1:0] done_o
);
    logic phase_q;
    // Slow receive memory stalls every other cycle
    always_ff @(posedge clk_sys_i) phase_q <= rst_n_i && !phase_q;
    assign req_o = {2{active_i}};
    assign done_o = {go_i[1], go_i[0] && (!slow_i || phase_q)};
endmodule

// ==== dv/tb_peripheral_dma_channel_control.sv ====
// Testbench for pdcc_top: register map, enable interlocks, transfers.
// Assumes pdcc_periph_model as partner and the bound checker.
`timescale 1ns/100ps
module tb_peripheral_dma_channel_control;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic active = 1'b0;
    logic [31:0] reg_rdata_o, rx_addr_o, tx_addr_o;
    logic rx_go_o, tx_go_o, rx_end_o, tx_end_o;
    logic [1:0] req, done;
    int n_mismatch = 0;
    int comparisons = 0;
    int n_rx = 0;
    int n_tx = 0;
    always #4 clk_sys_i = !clk_sys_i;
    always @(posedge clk_sys_i) begin
        n_rx <= n_rx + int'(rx_go_o && done[0]);
        n_tx <= n_tx + int'(tx_go_o && done[1]);
    end
    pdcc_top #(.XFER_BYTES(4)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .rx_req_i(req[0]), .tx_req_i(req[1]), .rx_go_o(rx_go_o), .tx_go_o(tx_go_o), .rx_addr_o(rx_addr_o),
        .tx_addr_o(tx_addr_o), .rx_done_i(done[0]), .tx_done_i(done[1]), .rx_end_o(rx_end_o),
        .tx_end_o(tx_end_o));
    pdcc_periph_model partner (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .active_i(active), .slow_i(1'b1),
        .go_i({tx_go_o, rx_go_o}), .req_o(req), .done_o(done));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, e);
    endtask
    task automatic step(input logic [31:0] w, input logic [31:0] e);
        wr(pdcc_pkg::ADDR_CTRL, w);
        rd(pdcc_pkg::ADDR_STATUS, e);
    endtask
    task automatic t_regs;
        rd(pdcc_pkg::ADDR_STATUS, 32'h0);
        rd(8'h3C, 32'h0);
        wr(pdcc_pkg::ADDR_RX_PTR, 32'h100);
        wr(pdcc_pkg::ADDR_RX_CNT, 32'h2);
        wr(pdcc_pkg::ADDR_RX_NPTR, 32'h800);
        wr(pdcc_pkg::ADDR_RX_NCNT, 32'hFFFF_0001);
        wr(pdcc_pkg::ADDR_TX_PTR, 32'h40);
        wr(pdcc_pkg::ADDR_TX_CNT, 32'h2);
        wr(pdcc_pkg::ADDR_TX_NPTR, 32'hA5C3_1F08);
        wr(pdcc_pkg::ADDR_TX_NCNT, 32'hFFFF_0003);
        rd(pdcc_pkg::ADDR_RX_NCNT, 32'h1);
        rd(pdcc_pkg::ADDR_RX_NPTR, 32'h800);
        rd(pdcc_pkg::ADDR_TX_NPTR, 32'hA5C3_1F08);
        rd(pdcc_pkg::ADDR_TX_NCNT, 32'h3);
        $display("test registers done");
    endtask
    task automatic t_ctrl;
        step(32'h000, 32'h000);
        step(32'h001, 32'h001);
        step(32'h100, 32'h101);
        step(32'h003, 32'h100);
        step(32'h201, 32'h001);
        step(32'h002, 32'h000);
        rd(pdcc_pkg::ADDR_CTRL, 32'h0);
        wr(pdcc_pkg::ADDR_CONFIG, 32'h1);
        step(32'h100, 32'h100);
        step(32'h002, 32'h000);
        step(32'h100, 32'h100);
        step(32'h001, 32'h001);
        step(32'h200, 32'h000);
        // Forbidden double enable on purpose
        step(32'h101, 32'h001);
        step(32'h002, 32'h000);
        wr(pdcc_pkg::ADDR_CONFIG, 32'h0);
        $display("test control done");
    endtask
    task automatic t_xfer;
        int i;
        wr(pdcc_pkg::ADDR_CTRL, 32'h101);
        active <= 1'b1;
        for (i = 0; i < 100 && !(rx_end_o && tx_end_o); i++) begin
            @(posedge clk_sys_i);
            #1;
        end
        chk(32'(i < 100), 32'h1);
        if (i >= 100) begin
            complete_run();
        end
        chk(32'(n_rx), 32'h3);
        chk(32'(n_tx), 32'h5);
        chk(rx_addr_o, 32'h804);
        chk(tx_addr_o, 32'hA5C3_1F14);
        chk({30'h0, rx_go_o, tx_go_o}, 32'h0);
        rd(pdcc_pkg::ADDR_RX_NCNT, 32'h0);
        step(32'h202, 32'h000);
        active <= 1'b0;
        $display("test transfer done");
    endtask
    task automatic t_half;
        wr(pdcc_pkg::ADDR_CONFIG, 32'h1);
        wr(pdcc_pkg::ADDR_TX_NPTR, 32'h200);
        wr(pdcc_pkg::ADDR_RX_NPTR, 32'h200);
        wr(pdcc_pkg::ADDR_TX_NCNT, 32'h2);
        wr(pdcc_pkg::ADDR_RX_NCNT, 32'h2);
        rd(pdcc_pkg::ADDR_RX_CNT, 32'h2);
        rd(pdcc_pkg::ADDR_TX_PTR, 32'h200);
        step(32'h001, 32'h001);
        step(32'h002, 32'h000);
        wr(pdcc_pkg::ADDR_CONFIG, 32'h0);
        $display("test half duplex done");
    endtask
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_ctrl();
        t_xfer();
        t_half();
        complete_run();
    end
endmodule
